// [inc/dac_stat_regs.vh]
`ifndef DAC_STAT_REGS_VH
`define DAC_STAT_REGS_VH

// Serial frame layout
`define FRAME_BITS 32
`define FRAME_CNT_W 6
`define FRAME_RW_BIT 31
`define FRAME_ADDR_HI 30
`define FRAME_ADDR_LO 24
`define FRAME_DATA_HI 23

// Register addresses
`define ADDR_RECAL_TRIGGER 7'h04
`define ADDR_RECAL_STATUS 7'h05
`define ADDR_OUTPUT_CONFIG_TWO 7'h06

// Recalibration trigger register
`define RECAL_TRIGGER_BIT 8

// Status register
`define RECAL_DONE_FLAG_BIT 12
`define RECAL_DONE_FLAG_RST 1'h0

// Second configuration register
`define OUTPUT_CONFIG_TWO_RST 24'h000040
`define TRACK_HOLD_DISABLE_BIT 7
`define CFG2_RSVD_ONE_BIT 6
`define UPDATE_RATE_HI 5
`define UPDATE_RATE_LO 4

// Update rate codes
`define UPDATE_RATE_0P8_MHZ 2'h0
`define UPDATE_RATE_1P05_MHZ 2'h1
`define UPDATE_RATE_0P7_MHZ 2'h2
`define UPDATE_RATE_0P95_MHZ 2'h3

// Synchroniser depth
`define SYNC_STAGES 2

`endif

// [tb/dac_status_output_config_two_regs_asserts.sv]
`timescale 1ns/1ps
module dac_status_output_config_two_regs_asserts
(
  input wire CORE_CLK_IN,
  input wire RESETN_IN,
  input wire SYNC_N_IN,
  input wire ALARM_PIN_ENABLE_IN,
  input wire RECAL_COMPLETE_IN,
  input wire ALARM_N_OE_OUT,
  input wire RECAL_START_OUT,
  input wire RECAL_DONE_FLAG_OUT,
  input wire TRACK_HOLD_DISABLE_OUT,
  input wire [1:0] UPDATE_RATE_OUT
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // Enabled completion event
  wire go = RECAL_COMPLETE_IN && ALARM_PIN_ENABLE_IN;
  property p_rst;
    $rose(RESETN_IN) |-> !TRACK_HOLD_DISABLE_OUT && UPDATE_RATE_OUT == 2'h0 && !ALARM_N_OE_OUT;
  endproperty
  a_rst: assert property (p_rst) else $error("bad value after reset");
  property p_start_width;
    RECAL_START_OUT |=> !RECAL_START_OUT;
  endproperty
  a_start_width: assert property (p_start_width) else $error("start pulse too long");
  property p_start_at_end;
    $rose(RECAL_START_OUT) |-> $past(SYNC_N_IN, 2);
  endproperty
  a_start_at_end: assert property (p_start_at_end) else $error("start inside frame");
  property p_done_set;
    RECAL_COMPLETE_IN |-> ##[1:2] RECAL_DONE_FLAG_OUT;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");
  property p_alarm_set;
    go |-> ##[1:2] ALARM_N_OE_OUT;
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm not driven");
  property p_alarm_cause;
    $rose(ALARM_N_OE_OUT) |-> $past(go) || $past(go, 2);
  endproperty
  a_alarm_cause: assert property (p_alarm_cause) else $error("alarm without cause");
  property p_alarm_release;
    $fell(ALARM_N_OE_OUT) |-> $past(SYNC_N_IN, 2);
  endproperty
  a_alarm_release: assert property (p_alarm_release) else $error("alarm freed in frame");
  property p_cfg_at_end;
    !$stable({TRACK_HOLD_DISABLE_OUT, UPDATE_RATE_OUT}) |-> $past(SYNC_N_IN, 2);
  endproperty
  a_cfg_at_end: assert property (p_cfg_at_end) else $error("config changed in frame");
endmodule // dac_status_output_config_two_regs_asserts
bind dac_status_output_config_two_regs dac_status_output_config_two_regs_asserts u_chk (.*);

// [tb/dac_status_output_config_two_regs_tb_top.sv]
`timescale 1ns/1ps
module dac_status_output_config_two_regs_tb_top;
  logic clk = 1'h0, rstn = 1'h0, en = 1'h0, cmp = 1'h0;
  logic [15:0] coef = 16'h0000;
  logic [31:0] rx;
  wire sclk, syn, sdi, sdo, an, aoe, st, dn, thd;
  wire [15:0] ac;
  wire [1:0] rate;
  // Open-drain alarm pin with pull-up
  wire pin = aoe ? an : 1'h1;
  int n_mismatch = 0, n_checks = 0, n_start = 0;
  dac_status_output_config_two_regs u_dut (.CORE_CLK_IN(clk), .RESETN_IN(rstn), .SCLK_IN(sclk),
    .SYNC_N_IN(syn), .SDI_IN(sdi), .ALARM_PIN_ENABLE_IN(en), .RECAL_COMPLETE_IN(cmp),
    .NEW_COEF_IN(coef), .SDO_OUT(sdo), .ALARM_N_OUT(an), .ALARM_N_OE_OUT(aoe),
    .RECAL_START_OUT(st), .RECAL_DONE_FLAG_OUT(dn), .ACTIVE_COEF_OUT(ac),
    .TRACK_HOLD_DISABLE_OUT(thd), .UPDATE_RATE_OUT(rate));
  spi_host_model u_host (.clk_in(clk), .sclk_out(sclk), .sync_n_out(syn), .sdi_out(sdi),
    .sdo_in(sdo));
  initial forever #4 clk = ~clk;
  always @(posedge clk) if (st === 1'h1) n_start <= n_start + 1;
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task wr(input logic [6:0] a, input logic [23:0] d);
    u_host.frame({1'h0, a, d}, rx);
    @(posedge clk);
  endtask
  // Reply comes in the following frame
  task rd(input logic [6:0] a);
    u_host.frame({1'h1, a, 24'h000000}, rx);
    u_host.frame(32'h00000000, rx);
    @(posedge clk);
  endtask
  task complete(input logic [15:0] c);
    cmp <= 1'h1;
    coef <= c;
    @(posedge clk);
    cmp <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  task t_reset;
    check("thd", thd, 1'h0);
    check("rate", rate, 2'h0);
    check("pin", pin, 1'h1);
    rd(7'h06);
    check("cfg2", rx, 32'h86000040);
    $display("t_reset done");
  endtask
  task t_cfg;
    for (int k = 0; k < 4; k++)
    begin
      wr(7'h06, {16'h0000, k[0], 1'h1, k[1:0], 4'h0});
      check("thd", thd, k[0]);
      check("rate", rate, k[1:0]);
      rd(7'h06);
      check("cfg2", rx, {24'h860000, k[0], 1'h1, k[1:0], 4'h0});
    end
    $display("t_cfg done");
  endtask
  task t_recal;
    en <= 1'h1;
    wr(7'h04, 24'h000100);
    check("starts", n_start, 1);
    check("busy", dn, 1'h0);
    complete(16'h1234);
    check("done", dn, 1'h1);
    check("coef", ac, 16'h1234);
    check("pin", pin, 1'h0);
    wr(7'h05, 24'h000000);
    check("pin", pin, 1'h0);
    rd(7'h05);
    check("status", rx, 32'h85001000);
    check("pin", pin, 1'h1);
    en <= 1'h0;
    wr(7'h04, 24'h000000);
    wr(7'h04, 24'h000100);
    check("starts", n_start, 2);
    check("busy", dn, 1'h0);
    complete(16'h5678);
    check("done", dn, 1'h1);
    check("coef", ac, 16'h5678);
    check("pin", pin, 1'h1);
    rd(7'h05);
    check("status", rx, 32'h85001000);
    $display("t_recal done");
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    repeat (4) @(posedge clk);
    t_reset;
    t_cfg;
    t_recal;
    summarize;
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    summarize;
  end
endmodule // dac_status_output_config_two_regs_tb_top

// [tb/spi_host_model.sv]
`timescale 1ns/1ps
module spi_host_model
(
  input wire logic clk_in,
  output logic sclk_out,
  output logic sync_n_out,
  output logic sdi_out,
  input wire logic sdo_in
);
  initial
  begin
    sclk_out = 1'h0;
    sync_n_out = 1'h1;
    sdi_out = 1'h0;
  end
  // Mode 1 frame, 32 bits MSB first, idle low clock, launch on rise
  // Each clock level lasts four core cycles, a 64 ns link period
  task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
    @(posedge clk_in);
    sync_n_out <= 1'h0;
    repeat (4) @(posedge clk_in);
    for (int i = 31; i >= 0; i--)
    begin
      sclk_out <= 1'h1;
      sdi_out <= tx[i];
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'h0;
      repeat (4) @(posedge clk_in);
      // Reply bit settled long before the next launch
      rx[i] = sdo_in;
    end
    sync_n_out <= 1'h1;
    // Released data line shows no stale bit
    sdi_out <= ~sdi_out;
    repeat (8) @(posedge clk_in);
  endtask
endmodule // spi_host_model

// [verilog/dac_status_output_config_two_regs.v]
`timescale 1ns/1ps
`include "dac_stat_regs.vh"

// Operation
// - Status at 05h, read only, bit31 set
// - Bit 12 shows recalibration done
// - Done flag never masked by pin enable
// - Enabled completion pulls alarm output low
// - Status read releases alarm output high
// - New coefficients used after completion
// - Config two at 06h, resets 000040h
// - Bit 31 one reads, zero writes
// - Bit 7 disables track and hold
// - Reserved bit 6 resets to one
// - Bits 5-4 select maximum update rate
// - Bits 30-24 address, reserved reset zero
// - Mode 1, active-low select, 32-bit frames
// - Trigger bit write starts recalibration
module dac_status_output_config_two_regs #(
  parameter COEF_W = 16
)
(
  input wire CORE_CLK_IN,
  input wire RESETN_IN,
  input wire SCLK_IN,
  input wire SYNC_N_IN,
  input wire SDI_IN,
  input wire ALARM_PIN_ENABLE_IN,
  input wire RECAL_COMPLETE_IN,
  input wire [COEF_W-1:0] NEW_COEF_IN,
  output reg SDO_OUT,
  output reg ALARM_N_OUT,
  output reg ALARM_N_OE_OUT,
  output reg RECAL_START_OUT,
  output reg RECAL_DONE_FLAG_OUT,
  output reg [COEF_W-1:0] ACTIVE_COEF_OUT,
  output reg TRACK_HOLD_DISABLE_OUT,
  output reg [1:0] UPDATE_RATE_OUT
);

  wire [2:0] pins_sync;
  wire sclk_s;
  wire sync_n_s;
  wire sdi_s;
  reg sclk_prev_reg;
  reg sync_n_prev_reg;
  wire sclk_rise;
  wire sclk_fall;
  wire frame_start;
  wire frame_end;
  reg [`FRAME_BITS-1:0] shift_in_reg;
  reg [`FRAME_BITS-1:0] shift_out_reg;
  reg [`FRAME_BITS-1:0] resp_reg;
  reg [`FRAME_CNT_W-1:0] bit_cnt_reg;
  reg recal_done_reg;
  reg track_hold_disable_reg;
  reg [1:0] update_rate_reg;
  reg alarm_active_reg;
  wire frame_ok;
  wire frame_read;
  wire [6:0] frame_addr;
  wire status_read;
  wire cfg2_write;
  wire cfg2_read;
  wire trigger_write;
  wire [`FRAME_BITS-1:0] status_word;
  wire [`FRAME_BITS-1:0] cfg2_word;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  pin_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk_in(CORE_CLK_IN),
    .resetn_in(RESETN_IN),
    .async_in({SDI_IN, SYNC_N_IN, SCLK_IN}),
    .reset_val_in(3'h6),
    .sync_out(pins_sync)
  );

  assign sclk_s = pins_sync[0];
  assign sync_n_s = pins_sync[1];
  assign sdi_s = pins_sync[2];

  // Edge history of synced pins
  always @(posedge CORE_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      sclk_prev_reg <= 1'b0;
      sync_n_prev_reg <= 1'b1;
    end
    else
    begin
      sclk_prev_reg <= sclk_s;
      sync_n_prev_reg <= sync_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_reg & ~sync_n_s;
  assign sclk_fall = ~sclk_s & sclk_prev_reg & ~sync_n_s;
  assign frame_start = ~sync_n_s & sync_n_prev_reg;
  assign frame_end = sync_n_s & ~sync_n_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame decode
  // full frames only
  assign frame_ok = frame_end && (bit_cnt_reg == `FRAME_BITS);
  assign frame_addr = shift_in_reg[`FRAME_ADDR_HI:`FRAME_ADDR_LO];
  assign frame_read = shift_in_reg[`FRAME_RW_BIT];
  assign status_read = frame_ok && frame_read && (frame_addr == `ADDR_RECAL_STATUS);
  assign cfg2_write = frame_ok && !frame_read && (frame_addr == `ADDR_OUTPUT_CONFIG_TWO);
  assign cfg2_read = frame_ok && frame_read && (frame_addr == `ADDR_OUTPUT_CONFIG_TWO);
  assign trigger_write = frame_ok && !frame_read && (frame_addr == `ADDR_RECAL_TRIGGER)
    && shift_in_reg[`RECAL_TRIGGER_BIT];

  // flag at bit 12, reserved zero
  assign status_word = {shift_in_reg[31:24], 11'h000, recal_done_reg, 12'h000};
  assign cfg2_word = {shift_in_reg[31:24], 16'h0000, track_hold_disable_reg, 1'b1,
    update_rate_reg, 4'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Serial shift engine
  always @(posedge CORE_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      shift_in_reg <= 32'h00000000;
      shift_out_reg <= 32'h00000000;
      bit_cnt_reg <= 6'h00;
      resp_reg <= 32'h00000000;
      SDO_OUT <= 1'b0;
    end
    else
    begin
      if (frame_start)
      begin
        // Load reply to previous read
        shift_out_reg <= resp_reg;
        bit_cnt_reg <= 6'h00;
      end
      else if (sclk_rise)
      begin
        // Drive on rising edge
        SDO_OUT <= shift_out_reg[`FRAME_BITS-1];
        shift_out_reg <= {shift_out_reg[`FRAME_BITS-2:0], 1'b0};
      end
      else if (sclk_fall)
      begin
        // Sample on falling edge
        shift_in_reg <= {shift_in_reg[`FRAME_BITS-2:0], sdi_s};
        if (bit_cnt_reg != 6'h3f)
          bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
      if (status_read)
        resp_reg <= status_word;
      else if (cfg2_read)
        resp_reg <= cfg2_word;
      else if (frame_ok)
        resp_reg <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Second configuration register
  always @(posedge CORE_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      track_hold_disable_reg <= 1'b0;
      update_rate_reg <= `UPDATE_RATE_0P8_MHZ;
    end
    else if (cfg2_write)
    begin
      track_hold_disable_reg <= shift_in_reg[`TRACK_HOLD_DISABLE_BIT];
      update_rate_reg <= shift_in_reg[`UPDATE_RATE_HI:`UPDATE_RATE_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Recalibration status and alarm
  always @(posedge CORE_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      recal_done_reg <= `RECAL_DONE_FLAG_RST;
      alarm_active_reg <= 1'b0;
      RECAL_START_OUT <= 1'b0;
    end
    else
    begin
      RECAL_START_OUT <= trigger_write;
      if (RECAL_COMPLETE_IN)
        recal_done_reg <= 1'b1;
      else if (trigger_write)
        recal_done_reg <= 1'b0;
      if (RECAL_COMPLETE_IN && ALARM_PIN_ENABLE_IN)
        alarm_active_reg <= 1'b1;
      else if (status_read)
        alarm_active_reg <= 1'b0;
    end
  end

  // Registered pin and status outputs
  always @(posedge CORE_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      ALARM_N_OUT <= 1'b0;
      ALARM_N_OE_OUT <= 1'b0;
      RECAL_DONE_FLAG_OUT <= 1'b0;
      ACTIVE_COEF_OUT <= {COEF_W{1'b0}};
      TRACK_HOLD_DISABLE_OUT <= 1'b0;
      UPDATE_RATE_OUT <= `UPDATE_RATE_0P8_MHZ;
    end
    else
    begin
      // Open drain: drive low only
      ALARM_N_OUT <= 1'b0;
      ALARM_N_OE_OUT <= alarm_active_reg;
      RECAL_DONE_FLAG_OUT <= recal_done_reg;
      if (RECAL_COMPLETE_IN)
        ACTIVE_COEF_OUT <= NEW_COEF_IN;
      TRACK_HOLD_DISABLE_OUT <= track_hold_disable_reg;
      UPDATE_RATE_OUT <= update_rate_reg;
    end
  end

endmodule // dac_status_output_config_two_regs

// [verilog/pin_sync.v]
`timescale 1ns/1ps
`include "dac_stat_regs.vh"

module pin_sync #(
  parameter WIDTH = 3
)
(
  input wire clk_in,
  input wire resetn_in,
  input wire [WIDTH-1:0] async_in,
  input wire [WIDTH-1:0] reset_val_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchroniser per pin
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_sync
      reg meta_reg;
      reg stable_reg;
      // First stage feeds only the second
      always @(posedge clk_in)
      begin
        if (!resetn_in)
        begin
          // Idle level of the pin, so no false edge follows reset
          meta_reg <= reset_val_in[i];
          stable_reg <= reset_val_in[i];
        end
        else
        begin
          meta_reg <= async_in[i];
          stable_reg <= meta_reg;
        end
      end
      assign sync_out[i] = stable_reg;
    end
  endgenerate

endmodule // pin_sync
